/* design/dph_consts.svh */
// Timing and field constants for the dual-port RAM port controller.
`ifndef DPH_CONSTS_SVH
`define DPH_CONSTS_SVH
`define DPH_CLK_PERIOD_NS 25
`define DPH_CYC_UP(ns) (((ns) + `DPH_CLK_PERIOD_NS - 1) / `DPH_CLK_PERIOD_NS)
`define DPH_FLAG_SETTLE_NS 20
`define DPH_WRITE_PULSE_NS 25
`define DPH_ACCESS_NS 25
`define DPH_FLOW_THROUGH_NS 20
`define DPH_TOKEN_RECOVERY_NS 15
`define DPH_TOKEN_IDX_W 3
`define DPH_TOKEN_BIT 0
`define DPH_CNT_W 8
`endif

/* design/dph_host.sv */
// Clocked controller driving one port of an asynchronous dual-port RAM.
// Overview of operation
// [RULE1] Device ports are independent; this controller drives one of them.
// [RULE2] Device holds eight token latches, each owned by one side.
// [RULE3] Write ends on rw rise with enable and data still held.
// [RULE4] Reads wait a flow-through delay before data is used.
// [RULE5] Array read asserts port enable and output enable, waits access time.
// [RULE6] Token read asserts token select with output enable, not port enable.
// [RULE7] Top array word is the right port mailbox.
// [RULE8] Second top word is the left port mailbox.
// [RULE9] Writing the far mailbox raises the far interrupt.
// [RULE10] Reading the own mailbox clears the own interrupt.
// [RULE11] Reading the far mailbox leaves its interrupt alone.
// [RULE12] While contended, a port cannot set or clear interrupts.
// [RULE13] Matching addresses are granted to one port; loser sees contention.
// [RULE14] Master drives contention flags; slave takes them as inputs.
// [RULE15] Writes wait until the contention input has settled and is clear.
// [RULE16] Token request writes zero, reads back, polls while it reads one.
// [RULE17] Token select or output enable drops for a gap before readback.
// [RULE18] Token access keeps port enable high, uses address 0-2, data bit 0.
// [RULE19] Zero written to a free latch shows zero here, one there.
// [RULE20] Owner writing one frees the latch or hands it to a waiter.
// [RULE21] Token read shows the latch value on all 16 lines, held.
// [RULE22] Simultaneous token requests are granted to exactly one side.
// [RULE23] After power-up all latches are free and interrupts inactive.
`default_nettype none
`include "dph_consts.svh"
module dph_host (
	// Clock, reset and enable.
	input  wire logic           clk_sys,
	input  wire logic           rst_b,
	input  wire logic           clk_en,
	// User command and response.
	input  wire logic           cmd_valid,
	output logic                cmd_ready,
	input  wire dph_pkg::dph_cmd_t cmd,
	output logic                resp_valid,
	output logic [15:0]         resp_data,
	output logic                mailbox_irq,
	output logic                contention,
	// Device port pins.
	output dph_pkg::dph_pins_t  pins,
	output logic [15:0]         data_o,
	output logic                data_oe,
	input  wire logic [15:0]    data_i,
	input  wire logic           busy_n,
	input  wire logic           int_n
);
	import dph_pkg::*;

	// -------------------------------------------------------------------
	// Timing counts
	// -------------------------------------------------------------------
	localparam logic [`DPH_CNT_W-1:0] T_SETTLE = `DPH_CNT_W'(`DPH_CYC_UP(`DPH_FLAG_SETTLE_NS));
	localparam logic [`DPH_CNT_W-1:0] T_WP = `DPH_CNT_W'(`DPH_CYC_UP(`DPH_WRITE_PULSE_NS));
	localparam logic [`DPH_CNT_W-1:0] T_ACC =
		`DPH_CNT_W'(`DPH_CYC_UP(`DPH_ACCESS_NS + `DPH_FLOW_THROUGH_NS));
	localparam logic [`DPH_CNT_W-1:0] T_GAP = `DPH_CNT_W'(`DPH_CYC_UP(`DPH_TOKEN_RECOVERY_NS));
	localparam dph_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 14'h0000};

	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_WRITE, S_WEND, S_READ, S_GAP} dph_state_t;

	// -------------------------------------------------------------------
	// Reset release and input synchronisers
	// -------------------------------------------------------------------
	logic        rst_q1;
	logic        rst_q2;
	logic [17:0] in_q1;
	logic [17:0] in_q2;
	logic [15:0] data_s;
	logic        busy_s;
	logic        int_s;

	// Reset is released through two flops so every flop reset by rst_q2 leaves reset together.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_q1 <= 1'b0;
			rst_q2 <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_q2 <= rst_q1;
		end
	end

	// Pins come from an unclocked device, so only the second stage is read.
	always_ff @(posedge clk_sys or negedge rst_q2) begin
		if (!rst_q2) begin
			in_q1 <= 18'h3FFFF;
			in_q2 <= 18'h3FFFF;
		end else if (clk_en) begin
			in_q1 <= {int_n, busy_n, data_i};
			in_q2 <= in_q1;
		end
	end
	assign data_s = in_q2[15:0];
	assign busy_s = in_q2[16];
	assign int_s  = in_q2[17];
	assign mailbox_irq = !int_s;
	assign contention  = !busy_s;

	// -------------------------------------------------------------------
	// Access sequencer
	// -------------------------------------------------------------------
	dph_state_t            state, next_state;
	logic [`DPH_CNT_W-1:0] cnt, next_cnt;
	dph_op_t               op, next_op;
	dph_pins_t             next_pins;
	logic [15:0]           next_data_o;
	logic                  next_data_oe;
	logic                  next_resp_valid;
	logic [15:0]           next_resp_data;
	logic                  is_token;

	assign is_token  = (op == DPH_TAKE) || (op == DPH_FREE);
	assign cmd_ready = (state == S_IDLE);

	// One step of the pin sequence per state; counters stretch every phase except S_IDLE and S_WEND.
	always_comb begin
		next_state      = state;
		next_cnt        = cnt;
		next_op         = op;
		next_pins       = pins;
		next_data_o     = data_o;
		next_data_oe    = data_oe;
		next_resp_valid = 1'b0;
		next_resp_data  = resp_data;
		unique case (state)
			S_IDLE: begin
				if (cmd_valid) begin
					next_op    = cmd.op;
					next_cnt   = T_SETTLE;
					next_state = S_SETUP;
					if (cmd.op == DPH_TAKE || cmd.op == DPH_FREE) begin
						// Port enable stays high; only the low address bits pick a latch.
						// An earlier array access may have left the byte selects low.
						// Together with token select low, that would be a forbidden pin state.
						next_pins.token_latch_select_n = 1'b0; // [RULE18]
						next_pins.high_byte_select_n   = 1'b1; // [RULE18]
						next_pins.low_byte_select_n    = 1'b1; // [RULE18]
						next_pins.addr = {11'h000, cmd.addr[`DPH_TOKEN_IDX_W-1:0]}; // [RULE18]
						next_data_o = {15'h0000, cmd.op == DPH_FREE}; // [RULE16] [RULE18]
					end else begin
						next_pins.port_enable_n      = 1'b0; // [RULE5]
						next_pins.high_byte_select_n = !cmd.byte_en[1];
						next_pins.low_byte_select_n  = !cmd.byte_en[0];
						next_pins.addr               = cmd.addr;
						next_data_o                  = cmd.data;
					end
				end
			end
			S_SETUP: begin
				if (cnt != `DPH_CNT_W'(0)) begin
					next_cnt = cnt - `DPH_CNT_W'(1);
				end else if (!is_token && !busy_s) begin
					// Contention flag still asserted: hold off the array access.
					next_state = S_SETUP; // [RULE15]
				end else if (op == DPH_RD) begin
					next_pins.out_enable_n = 1'b0; // [RULE5]
					next_cnt               = T_ACC; // [RULE4]
					next_state             = S_READ;
				end else begin
					next_pins.rw = 1'b0;
					next_data_oe = 1'b1;
					next_cnt     = T_WP;
					next_state   = S_WRITE;
				end
			end
			S_WRITE: begin
				if (cnt != `DPH_CNT_W'(0)) begin
					next_cnt = cnt - `DPH_CNT_W'(1);
				end else begin
					// The rw rise is the terminating edge; enable and data stay one cycle more.
					next_pins.rw = 1'b1; // [RULE3]
					next_state   = S_WEND;
				end
			end
			S_WEND: begin
				next_pins.port_enable_n        = 1'b1;
				next_pins.token_latch_select_n = 1'b1;
				next_data_oe                   = 1'b0;
				if (op == DPH_TAKE) begin
					next_cnt   = T_GAP; // [RULE17]
					next_state = S_GAP;
				end else begin
					next_resp_valid = 1'b1;
					next_state      = S_IDLE;
				end
			end
			S_GAP: begin
				if (cnt != `DPH_CNT_W'(0)) begin
					next_cnt = cnt - `DPH_CNT_W'(1);
				end else begin
					next_pins.token_latch_select_n = 1'b0; // [RULE6]
					next_pins.out_enable_n         = 1'b0; // [RULE6]
					next_cnt                       = T_ACC;
					next_state                     = S_READ;
				end
			end
			S_READ: begin
				if (cnt != `DPH_CNT_W'(0)) begin
					next_cnt = cnt - `DPH_CNT_W'(1);
				end else begin
					next_resp_data                 = data_s; // [RULE4]
					next_pins.out_enable_n         = 1'b1;
					next_pins.port_enable_n        = 1'b1;
					next_pins.token_latch_select_n = 1'b1;
					if (op == DPH_TAKE && data_s[`DPH_TOKEN_BIT]) begin
						// Far side owns it; poll again after a recovery gap. No timeout.
						next_cnt   = T_GAP; // [RULE16]
						next_state = S_GAP;
					end else begin
						next_resp_valid = 1'b1;
						next_state      = S_IDLE;
					end
				end
			end
		endcase
	end

	// Registers only; clk_en freezes all sequencing state.
	always_ff @(posedge clk_sys or negedge rst_q2) begin
		if (!rst_q2) begin
			state      <= S_IDLE;
			cnt        <= `DPH_CNT_W'(0);
			op         <= DPH_RD;
			pins       <= PINS_IDLE;
			data_o     <= 16'h0000;
			data_oe    <= 1'b0;
			resp_valid <= 1'b0;
			resp_data  <= 16'h0000;
		end else if (clk_en) begin
			state      <= next_state;
			cnt        <= next_cnt;
			op         <= next_op;
			pins       <= next_pins;
			data_o     <= next_data_o;
			data_oe    <= next_data_oe;
			resp_valid <= next_resp_valid;
			resp_data  <= next_resp_data;
		end
	end

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_q2 || !clk_en);

	wr_term_a: assert property ($rose(pins.rw) |-> data_oe && // [RULE3]
		(!pins.port_enable_n || !pins.token_latch_select_n)) else $error("write ended without data held");
	rd_hold_a: assert property ($fell(pins.out_enable_n) |-> !pins.out_enable_n[*3]) // [RULE4]
		else $error("read shorter than access plus flow-through");
	rd_enable_a: assert property (!pins.out_enable_n |-> // [RULE5]
		(pins.port_enable_n != pins.token_latch_select_n)) else $error("read without one select");
	token_rd_a: assert property ((state == S_READ && is_token) |-> // [RULE6]
		!pins.token_latch_select_n && pins.port_enable_n) else $error("token read uses port enable");
	busy_wait_a: assert property (($fell(pins.rw) && !pins.port_enable_n) |-> $past(busy_s)) // [RULE15]
		else $error("array write begun during contention");
	take_zero_a: assert property (($fell(pins.rw) && op == DPH_TAKE) |-> !data_o[0] ##1 !data_o[0]) // [RULE16]
		else $error("token request does not write zero");
	gap_a: assert property (($fell(pins.out_enable_n) && !pins.token_latch_select_n) |-> // [RULE17]
		$past(pins.token_latch_select_n)) else $error("no recovery gap before token read");
	token_sel_a: assert property (!pins.token_latch_select_n |-> pins.port_enable_n && // [RULE18]
		pins.high_byte_select_n && pins.low_byte_select_n && pins.addr[13:3] == 11'h000)
		else $error("token access with array selects");

	rd_done_c: cover property (resp_valid && op == DPH_RD);
	take_poll_c: cover property (state == S_READ ##1 state == S_GAP);
	busy_stall_c: cover property (state == S_SETUP && cnt == `DPH_CNT_W'(0) && !busy_s);
endmodule : dph_host
`default_nettype wire

/* design/dph_pkg.sv */
// Types shared by the dual-port RAM port controller.
`default_nettype none
package dph_pkg;
	typedef enum logic [1:0] {DPH_RD, DPH_WR, DPH_TAKE, DPH_FREE} dph_op_t;
	typedef struct packed {
		dph_op_t     op;
		logic [13:0] addr;
		logic [15:0] data;
		logic [1:0]  byte_en;
	} dph_cmd_t;
	typedef struct packed {
		logic        port_enable_n;
		logic        rw;
		logic        out_enable_n;
		logic        token_latch_select_n;
		logic        high_byte_select_n;
		logic        low_byte_select_n;
		logic [13:0] addr;
	} dph_pins_t;
endpackage : dph_pkg
`default_nettype wire

/* testbench/dph_dev_model.sv */
// Behavioural model of the device port that the controller drives.
`default_nettype none
module dph_dev_model (
	// Controller pins and the resolved data line.
	input  wire dph_pkg::dph_pins_t pins,
	input  wire logic [15:0]        data_o,
	input  wire logic               data_oe,
	output logic [15:0]             bus,
	output logic                    int_n,
	// Contention seen by this port.
	input  wire logic               busy_in,
	output logic                    busy_n
);
	import dph_pkg::*;
	logic [15:0]     mem [0:16383];
	logic [1:0][7:0] own;
	logic [1:0][7:0] req;
	logic [15:0]     last = 16'h0;
	logic [15:0]     tokq;
	logic            irq_r_n;
	dph_pins_t       q;
	assign busy_n = busy_in;
	// An undriven line shows the inverse of its last value, so stale data never looks valid.
	always_comb begin
		if (data_oe) bus = data_o;
		else if (!pins.out_enable_n && !pins.token_latch_select_n) bus = tokq;
		else if (!pins.out_enable_n && !pins.port_enable_n) bus = mem[pins.addr];
		else bus = ~last;
	end
	always @(bus) if (data_oe || !pins.out_enable_n) last = bus;
	initial begin
		own     = '0;
		req     = '0;
		int_n   = 1'b1;
		irq_r_n = 1'b1;
		tokq    = 16'hFFFF;
		q       = '1;
	end
	// Writes end on whichever of strobe or select rises first.
	always @(pins) begin
		if (!q.port_enable_n && !q.rw && (pins.rw || pins.port_enable_n)) begin
			if (!q.high_byte_select_n) mem[q.addr][15:8] = bus[15:8];
			if (!q.low_byte_select_n) mem[q.addr][7:0] = bus[7:0];
			if (q.addr == 14'h3FFF && busy_n) irq_r_n = 1'b0;
		end
		if (!q.token_latch_select_n && !q.rw && (pins.rw || pins.token_latch_select_n))
			tok_wr(0, q.addr[2:0], bus[0]);
		if (q.out_enable_n && !pins.out_enable_n && !pins.token_latch_select_n)
			tokq = {16{!own[0][pins.addr[2:0]]}};
		if (!pins.port_enable_n && !pins.out_enable_n && pins.addr == 14'h3FFE && busy_n)
			int_n = 1'b1;
		q = pins;
	end
	task automatic tok_wr(input int s, input logic [2:0] i, input logic b);
		if (!b) begin
			if (!own[0][i] && !own[1][i]) own[s][i] = 1'b1;
			else if (!own[s][i]) req[s][i] = 1'b1;
		end else begin
			req[s][i] = 1'b0;
			if (own[s][i]) begin
				own[s][i] = 1'b0;
				if (req[1-s][i]) begin
					own[1-s][i] = 1'b1;
					req[1-s][i] = 1'b0;
				end
			end
		end
	endtask : tok_wr
	task automatic far_wr(input logic [13:0] a, input logic [15:0] d);
		mem[a] = d;
		if (a == 14'h3FFE) int_n = 1'b0;
	endtask : far_wr
endmodule : dph_dev_model
`default_nettype wire

/* testbench/dual_port_ram_arbiter_mailbox_sem_bench.sv */
// Self-checking bench for the dual-port RAM port controller.
`default_nettype none
module dual_port_ram_arbiter_mailbox_sem_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import dph_pkg::*;
	logic        clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1, cmd_valid = 1'b0, busy_in = 1'b1;
	logic        cmd_ready, resp_valid, mailbox_irq, contention, data_oe, int_n, busy_n;
	logic [15:0] resp_data, data_o, bus, d;
	logic [31:0] seed = 32'hC7B9, r1, r2;
	logic [13:0] a;
	logic [16:0] e;
	logic [16:0] expq [$];
	dph_cmd_t    cmd = '0;
	dph_pins_t   pins;
	int          errors = 0, checks_done = 0, n_resp = 0, cyc = 0, n0;
	dph_host u_dph_host (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd(cmd), .resp_valid(resp_valid), .resp_data(resp_data),
		.mailbox_irq(mailbox_irq), .contention(contention), .pins(pins), .data_o(data_o),
		.data_oe(data_oe), .data_i(bus), .busy_n(busy_n), .int_n(int_n));
	dph_dev_model u_dph_dev_model (.pins(pins), .data_o(data_o), .data_oe(data_oe), .bus(bus),
		.int_n(int_n), .busy_in(busy_in), .busy_n(busy_n));
	initial forever #12.5 clk_sys = ~clk_sys;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_data
	task automatic chk_bit(input logic got, input logic exp);
		chk_data({15'h0, got}, {15'h0, exp});
	endtask : chk_bit
	// Issue one command and note its expected answer; block until it completes.
	task automatic do_cmd(input dph_op_t op, input logic [13:0] ad, input logic [15:0] dt,
		input logic [1:0] be, input logic chk, input logic [15:0] exp);
		int k;
		@(negedge clk_sys);
		cmd = '{op, ad, dt, be};
		cmd_valid = 1'b1;
		expq.push_back({chk, exp});
		k = n_resp;
		@(posedge clk_sys iff (cmd_ready && clk_en));
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		wait (n_resp != k);
	endtask : do_cmd
	// The answer is compared against the oldest note on the queue.
	// A pulse held by a frozen clock enable is counted once, at the edge that consumes it.
	always @(posedge clk_sys) if (resp_valid && clk_en) begin
		e = expq.pop_front();
		if (e[16]) chk_data(resp_data, e[15:0]);
		n_resp++;
	end
	// Cuts a hang short; the ceiling is well above the several hundred cycles the tests need.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys) rst_b = 1'b1;
		repeat (3) @(posedge clk_sys);
		chk_bit(mailbox_irq, 1'b0);
		chk_bit(pins.port_enable_n & pins.token_latch_select_n, 1'b1);
		chk_bit(cmd_ready, 1'b1);
		$display("Test reset done");
		// Whole word, then one random byte over it, then read back the merge.
		for (int n = 0; n < 8; n++) begin
			r1 = xs();
			r2 = xs();
			a = {1'b0, r1[12:0]};
			do_cmd(DPH_WR, a, r1[31:16], 2'b11, 1'b0, 16'h0);
			do_cmd(DPH_WR, a, r2[15:0], {r2[16], ~r2[16]}, 1'b0, 16'h0);
			d = r2[16] ? {r2[15:8], r1[23:16]} : {r1[31:24], r2[7:0]};
			do_cmd(DPH_RD, a, 16'h0, 2'b11, 1'b1, d);
		end
		$display("Test array done");
		u_dph_dev_model.far_wr(14'h3FFE, 16'hA5C3);
		repeat (5) @(posedge clk_sys);
		chk_bit(mailbox_irq, 1'b1);
		do_cmd(DPH_WR, 14'h3FFF, 16'h5A3C, 2'b11, 1'b0, 16'h0);
		chk_bit(u_dph_dev_model.irq_r_n, 1'b0);
		n0 = n_resp;
		fork
			do_cmd(DPH_RD, 14'h3FFF, 16'h0, 2'b11, 1'b1, 16'h5A3C);
			begin
				// Freeze the controller in mid-read; no answer may appear while clk_en is low.
				repeat (3) @(posedge clk_sys);
				@(negedge clk_sys) clk_en = 1'b0;
				repeat (10) @(posedge clk_sys);
				chk_data(16'(n_resp - n0), 16'h0);
				@(negedge clk_sys) clk_en = 1'b1;
			end
		join
		repeat (5) @(posedge clk_sys);
		chk_bit(mailbox_irq, 1'b1);
		do_cmd(DPH_RD, 14'h3FFE, 16'h0, 2'b11, 1'b1, 16'hA5C3);
		repeat (5) @(posedge clk_sys);
		chk_bit(mailbox_irq, 1'b0);
		$display("Test mailbox done");
		@(negedge clk_sys) busy_in = 1'b0;
		repeat (5) @(posedge clk_sys);
		chk_bit(contention, 1'b1);
		n0 = n_resp;
		fork
			do_cmd(DPH_WR, 14'h0123, 16'h8E71, 2'b11, 1'b0, 16'h0);
			begin
				repeat (20) @(posedge clk_sys);
				chk_data(16'(n_resp - n0), 16'h0);
				@(negedge clk_sys) busy_in = 1'b1;
			end
		join
		do_cmd(DPH_RD, 14'h0123, 16'h0, 2'b11, 1'b1, 16'h8E71);
		$display("Test contention done");
		for (int i = 0; i < 8; i++)
			do_cmd(DPH_TAKE, {r1[10:0], 3'(i)}, 16'h0, 2'b11, 1'b1, 16'h0);
		do_cmd(DPH_FREE, 14'h0003, 16'h1, 2'b11, 1'b0, 16'h0);
		chk_bit(u_dph_dev_model.own[0][3], 1'b0);
		u_dph_dev_model.tok_wr(1, 3'h3, 1'b0);
		n0 = n_resp;
		fork
			do_cmd(DPH_TAKE, 14'h0003, 16'h0, 2'b11, 1'b1, 16'h0);
			begin
				repeat (40) @(posedge clk_sys);
				chk_data(16'(n_resp - n0), 16'h0);
				chk_data(u_dph_dev_model.tokq, 16'hFFFF);
				u_dph_dev_model.tok_wr(1, 3'h3, 1'b1);
			end
		join
		for (int i = 0; i < 8; i++)
			do_cmd(DPH_FREE, 14'(i), 16'h1, 2'b11, 1'b0, 16'h0);
		chk_data({8'h00, u_dph_dev_model.own[0]}, 16'h0000);
		$display("Test tokens done");
		tally_and_finish();
	end
endmodule : dual_port_ram_arbiter_mailbox_sem_bench
`default_nettype wire
